// file: link_pkg.sv
// package: constants, format type and lane helpers of the mac port link
package link_pkg;
    // lane geometry
    localparam int NPORTS      = 8;
    localparam int SEG_BITS    = 10;
    localparam int WORD_W      = NPORTS * SEG_BITS;
    localparam int BUF_DEPTH   = 2;
    localparam int SS_SYNC_BIT = 3;
    localparam int SS_CLK_BIT  = 4;
    // counts and reset values
    localparam logic [1:0] STRAP_DEFAULT = 2'h3;
    localparam logic [3:0] SEG_LAST      = 4'h9;
    localparam logic [3:0] DIBIT_LAST    = 4'h4;
    localparam logic [3:0] REPEAT_LAST   = 4'h9;
    // link clock made by dividing clk_sys
    localparam int CLK_PERIOD_NS  = 25;
    localparam int LINK_PERIOD_NS = 200;
    localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [3:0] HALF_LAST = 4'(LINK_HALF_CYC - 1);

    typedef enum logic [1:0] {
        FMT_SMII        = 2'b00,
        FMT_SOURCE_SYNC = 2'b01,
        FMT_RMII        = 2'b10
    } fmt_t;

    // strap value to format, 1x means rmii
    function automatic fmt_t decode_fmt(input logic [1:0] strap);
        if (strap[1])
            return FMT_RMII;
        return strap[0] ? FMT_SOURCE_SYNC : FMT_SMII;
    endfunction

    // bit idx of every port's segment
    function automatic logic [NPORTS-1:0] lane_bits(input logic [WORD_W-1:0] word, input logic [3:0] idx);
        logic [NPORTS-1:0] b;
        b = '0;
        for (int p = 0; p < NPORTS; p++)
            b[p] = word[p*SEG_BITS + int'(idx)];
        return b;
    endfunction

    // write bit idx of every port's segment
    function automatic logic [WORD_W-1:0] place_bits(input logic [WORD_W-1:0] word, input logic [3:0] idx,
                                                     input logic [NPORTS-1:0] b);
        logic [WORD_W-1:0] w;
        w = word;
        for (int p = 0; p < NPORTS; p++)
            w[p*SEG_BITS + int'(idx)] = b[p];
        return w;
    endfunction
endpackage

// file: link_sva.sv
// checker: timing and level rules watched on the link pins
`timescale 1ns/1ps
module link_sva import link_pkg::*; (
    // clock, reset and strap
    input wire logic              clk_sys,
    input wire logic              nrst,
    input wire logic [1:0]        mode_strap,
    // link pins
    input wire logic              refclk,
    input wire logic [NPORTS-1:0] txd0,
    input wire logic [NPORTS-1:0] txd1,
    input wire logic [NPORTS-1:0] tx_en,
    input wire logic              sync,
    input wire logic [NPORTS-1:0] rxd0,
    input wire logic [NPORTS-1:0] rxd1,
    input wire logic [NPORTS-1:0] crs_dv
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // format flags from the strap
    logic ss;
    logic smii;
    assign ss   = (mode_strap == 2'b01);
    assign smii = (mode_strap == 2'b00);
    // divided link clock halves
    sequence four_high(s);
        s[*4] ##1 !s;
    endsequence
    sequence four_low(s);
        (!s)[*4] ##1 s;
    endsequence
    refclk_high_a: assert property (!ss && $rose(refclk) |-> four_high(refclk)) else $error("refclk high");
    refclk_low_a: assert property (!ss && $fell(refclk) |-> four_low(refclk)) else $error("refclk low");
    tx_clock_a: assert property (ss && $rose(tx_en[4]) |-> four_high(tx_en[4])) else $error("tx clock");
    rx_clock_a: assert property (ss && $rose(crs_dv[4]) |-> four_high(crs_dv[4])) else $error("rx clock");
    ss_unused_a: assert property (ss |-> (crs_dv & 8'he7) == 8'h00) else $error("unused carrier pins");
    rx_sync_edge_a: assert property (ss && $changed(crs_dv[3]) |-> $fell(crs_dv[4])) else $error("rx sync edge");
    rx_data_edge_a: assert property (ss && $changed(rxd0) |-> $fell(crs_dv[4])) else $error("rx data edge");
    rx_sync_period_a: assert property (ss && $rose(crs_dv[3]) |-> ##80 $rose(crs_dv[3])) else $error("rx sync");
    smii_sync_period_a: assert property (smii && $rose(sync) |-> ##80 $rose(sync)) else $error("smii sync");
    smii_crs_low_a: assert property (smii |-> crs_dv == 8'h00) else $error("smii carrier not low");
    serial_rxd1_a: assert property (!mode_strap[1] |-> rxd1 == 8'h00) else $error("rxd1 not low");
    rx_timing_a: assert property (!ss && $changed(rxd0) |-> !refclk) else $error("rx data off refclk");
endmodule

// file: mac_link_if.sv
// interface: pins between the phy end and the mac end
`timescale 1ns/1ps
interface mac_link_if ();
    import link_pkg::*;
    logic              refclk;
    logic [NPORTS-1:0] txd0;
    logic [NPORTS-1:0] txd1;
    logic [NPORTS-1:0] tx_en;
    logic              sync;
    logic [NPORTS-1:0] rxd0;
    logic [NPORTS-1:0] rxd1;
    logic [NPORTS-1:0] crs_dv;
    modport phy (output refclk, rxd0, rxd1, crs_dv, input txd0, txd1, tx_en, sync);
    modport mac (input refclk, rxd0, rxd1, crs_dv, output txd0, txd1, tx_en, sync);
endinterface

// file: mac_port_end.sv
// module: mac end of the link, sends transmit lanes and captures receive lanes
`timescale 1ns/1ps
module mac_port_end import link_pkg::*; (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // format strap and speed
    input  wire logic [1:0]        mode_strap,
    input  wire logic              slow_mode,
    // link pins
    mac_link_if.mac                lnk,
    // words to send
    input  wire logic              tx_valid,
    output logic                   tx_ready,
    input  wire logic [WORD_W-1:0] tx_word,
    input  wire logic [NPORTS-1:0] tx_en_mask,
    // words received
    output logic                   rx_valid,
    output logic [WORD_W-1:0]      rx_word,
    output logic [NPORTS-1:0]      rx_carrier
);
    logic [1:0]        strap_s1, strap_s2;
    fmt_t              fmt_reg;
    logic              fmt_done_reg, is_rmii, is_ss;
    logic [3:0]        div_reg;
    logic              lclk_reg, half_end;
    logic [NPORTS-1:0] rxd0_s1, rxd0_s2, rxd1_s1, rxd1_s2, crs_s1, crs_s2;
    logic              ref_s1, ref_s2, ref_d, rclk_d;
    logic              ref_rise, tstep, twrap, tload, buf_valid;
    logic [WORD_W+NPORTS-1:0] buf_data;
    logic [WORD_W-1:0] tcur_reg, racc_reg, racc_next;
    logic [NPORTS-1:0] ten_reg, ren_reg;
    logic [3:0]        tpos_reg, trep_reg, rpos_reg, rrep_reg, ridx, tidx;
    logic              sstart_reg, rtake, rstart, rseg_end;
    logic [NPORTS-1:0] txd0_reg, txd1_reg, txen_reg;
    logic              sync_reg;

    // strap and link pins through two flops
    always_ff @(posedge clk_sys) begin
        {strap_s1, ref_s1, rxd0_s1, rxd1_s1, crs_s1} <= {mode_strap, lnk.refclk, lnk.rxd0, lnk.rxd1, lnk.crs_dv};
        {strap_s2, ref_s2, rxd0_s2, rxd1_s2, crs_s2} <= {strap_s1, ref_s1, rxd0_s1, rxd1_s1, crs_s1};
        ref_d  <= ref_s2;
        rclk_d <= crs_s2[SS_CLK_BIT];
    end

    // format latched once after reset release
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            fmt_reg      <= decode_fmt(STRAP_DEFAULT);
            fmt_done_reg <= 1'b0;
        end else if (!fmt_done_reg) begin
            fmt_reg      <= decode_fmt(strap_s2);
            fmt_done_reg <= 1'b1;
        end
    end
    assign is_rmii = fmt_reg == FMT_RMII;
    assign is_ss   = fmt_reg == FMT_SOURCE_SYNC;

    // own transmit clock divider
    assign half_end = div_reg == HALF_LAST;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {div_reg, lclk_reg} <= '0;
        end else begin
            div_reg <= half_end ? 4'h0 : div_reg + 4'h1;
            if (half_end)
                lclk_reg <= !lclk_reg;
        end
    end

    // transmit side steps after each reference rise, or on own falling edge
    assign ref_rise = ref_s2 && !ref_d;
    assign tstep    = is_ss ? (half_end && lclk_reg) : ref_rise;
    assign twrap    = is_rmii ? (tpos_reg >= DIBIT_LAST) : (tpos_reg == SEG_LAST);
    assign tload    = tstep && twrap && (is_rmii || !slow_mode || trep_reg == REPEAT_LAST); // [R17]

    stream_buf2 #(.WIDTH(WORD_W + NPORTS), .DEPTH(BUF_DEPTH)) u_buf (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   ({tx_en_mask, tx_word}),
        .out_valid (buf_valid),
        .out_ready (tload),
        .out_data  (buf_data)
    );

    // transmit position, repeat count and current word
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {trep_reg, tcur_reg, ten_reg} <= '0;
            tpos_reg <= SEG_LAST; // first step wraps, no short sync after reset
        end else if (tstep) begin
            tpos_reg <= twrap ? 4'h0 : tpos_reg + 4'h1;
            if (twrap && !is_rmii)
                trep_reg <= (!slow_mode || trep_reg == REPEAT_LAST) ? 4'h0 : trep_reg + 4'h1; // [R17]
            if (tload) begin
                tcur_reg <= buf_valid ? buf_data[WORD_W-1:0] : '0;
                ten_reg  <= buf_valid ? buf_data[WORD_W +: NPORTS] : '0; // [R1]
            end
        end
    end

    // transmit pins
    assign tidx = is_rmii ? {tpos_reg[2:0], 1'b0} : tpos_reg;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {txd0_reg, txd1_reg, txen_reg, sync_reg} <= '0;
        end else begin
            txd0_reg <= lane_bits(tcur_reg, tidx); // [R19]
            txd1_reg <= is_rmii ? lane_bits(tcur_reg, tidx | 4'h1) : '0;
            sync_reg <= !is_rmii && tpos_reg == 4'h0; // [R13] [R14]
            txen_reg <= is_rmii ? ten_reg : '0; // [R1] [R2]
            if (is_ss)
                txen_reg[SS_CLK_BIT] <= lclk_reg; // [R3]
        end
    end
    assign lnk.txd0  = txd0_reg;
    assign lnk.txd1  = txd1_reg;
    assign lnk.tx_en = txen_reg;
    assign lnk.sync  = sync_reg;

    // receive capture, second receive bit only in rmii
    assign rtake  = is_ss ? (crs_s2[SS_CLK_BIT] && !rclk_d) : ref_rise;
    assign rstart = is_ss ? crs_s2[SS_SYNC_BIT] : sstart_reg;
    always_comb begin
        ridx      = is_rmii ? {rpos_reg[2:0], 1'b0} : (rstart ? 4'h0 : rpos_reg);
        racc_next = place_bits(racc_reg, ridx, rxd0_s2);
        if (is_rmii)
            racc_next = place_bits(racc_next, ridx | 4'h1, rxd1_s2); // [R8]
    end
    assign rseg_end = is_rmii ? (rpos_reg == DIBIT_LAST) : (ridx == SEG_LAST);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {rpos_reg, rrep_reg, racc_reg, ren_reg, sstart_reg} <= '0;
            {rx_valid, rx_word, rx_carrier} <= '0;
        end else begin
            rx_valid <= 1'b0;
            if (ref_rise)
                sstart_reg <= sync_reg;
            if (rtake && is_rmii && crs_s2 == '0) begin
                rpos_reg <= 4'h0;
            end else if (rtake) begin
                racc_reg <= racc_next;
                ren_reg  <= (ridx == 4'h0) ? crs_s2 : (ren_reg | crs_s2);
                rpos_reg <= rseg_end ? 4'h0 : (is_rmii ? rpos_reg : ridx) + 4'h1;
                if (rseg_end) begin
                    if (!is_rmii)
                        rrep_reg <= (!slow_mode || rrep_reg == REPEAT_LAST) ? 4'h0 : rrep_reg + 4'h1;
                    rx_valid   <= is_rmii || !slow_mode || rrep_reg == 4'h0;
                    rx_word    <= racc_next;
                    rx_carrier <= is_rmii ? (ren_reg | crs_s2) : '0;
                end
            end
        end
    end
endmodule

// file: octal_phy_reduced_mac_port_tb.sv
// testbench: phy end and mac end joined back to back over the link
`timescale 1ns/1ps
module octal_phy_reduced_mac_port_tb;
    import link_pkg::*;
    logic                 clk_sys = 1'b0;
    logic                 nrst = 1'b0;
    logic [1:0]           mode_strap = 2'b11;
    logic                 slow_mode = 1'b0;
    logic                 send_valid = 1'b0;
    logic                 tx_valid = 1'b0;
    logic [WORD_W-1:0]    send_word = '0;
    logic [WORD_W-1:0]    tx_word = '0;
    logic [NPORTS-1:0]    send_carrier = '0;
    logic [NPORTS-1:0]    tx_en_mask = '0;
    logic                 send_ready, tx_ready, got_valid, rx_valid;
    logic [WORD_W-1:0]    got_word, rx_word, ew;
    logic [NPORTS-1:0]    got_en, rx_carrier, em;
    fmt_t                 fmt;
    logic [31:0]          rng = 32'h331b4e7c;
    int                   n_errors = 0;
    int                   num_checks = 0;
    int                   k;
    logic                 armed = 1'b0;
    logic [WORD_W+7:0]    q_down[$], q_up[$];
    logic [1:0]           straps [6] = '{2'b11, 2'b10, 2'b00, 2'b00, 2'b01, 2'b01};
    logic                 slows [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    // clock
    always #12.5 clk_sys = ~clk_sys;
    mac_link_if lnk ();
    phy_port_end phy_port_end_inst (.clk_sys(clk_sys), .nrst(nrst), .mode_strap(mode_strap),
        .slow_mode(slow_mode), .fmt(fmt), .lnk(lnk), .send_valid(send_valid), .send_ready(send_ready),
        .send_word(send_word), .send_carrier(send_carrier), .got_valid(got_valid), .got_word(got_word),
        .got_en(got_en));
    mac_port_end mac_port_end_inst (.clk_sys(clk_sys), .nrst(nrst), .mode_strap(mode_strap),
        .slow_mode(slow_mode), .lnk(lnk), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
        .tx_en_mask(tx_en_mask), .rx_valid(rx_valid), .rx_word(rx_word), .rx_carrier(rx_carrier));
    link_sva link_sva_inst (.clk_sys(clk_sys), .nrst(nrst), .mode_strap(mode_strap), .refclk(lnk.refclk),
        .txd0(lnk.txd0), .txd1(lnk.txd1), .tx_en(lnk.tx_en), .sync(lnk.sync), .rxd0(lnk.rxd0),
        .rxd1(lnk.rxd1), .crs_dv(lnk.crs_dv));
    // xorshift source
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // expected format from the strap
    function automatic fmt_t exp_fmt(input logic [1:0] s);
        if (s[1])
            return FMT_RMII;
        return s[0] ? FMT_SOURCE_SYNC : FMT_SMII;
    endfunction
    // serial formats replace the per-port mask by a fixed value
    function automatic logic [7:0] exp_mask(input logic serial, input logic [7:0] m, input logic [7:0] fill);
        return serial ? fill : m;
    endfunction
    task automatic chk_word(input string what, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_small(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // offer n words back to back, corner values first
    task automatic push_words(input bit up, input int n);
        logic [WORD_W-1:0] w;
        logic [7:0] m;
        int t;
        @(posedge clk_sys);
        #2;
        for (int i = 0; i < n; i++) begin
            w = WORD_W'({rnd(), rnd(), rnd()});
            m = 8'(rnd());
            if (i == 0)
                w = '1;
            w[0] = 1'b1;
            m = (mode_strap[1] || i != 1) ? (m | 8'h01) : 8'h00;
            if (up)
                {tx_valid, tx_word, tx_en_mask} = {1'b1, w, m};
            else
                {send_valid, send_word, send_carrier} = {1'b1, w, m};
            t = 0;
            do @(posedge clk_sys); while ((up ? tx_ready : send_ready) !== 1'b1 && ++t < 4000);
            if (t >= 4000)
                n_errors++;
            if (up)
                q_up.push_back({w, m});
            else
                q_down.push_back({w, m});
            #2;
        end
        if (up)
            tx_valid = 1'b0;
        else
            send_valid = 1'b0;
    endtask
    // receive monitors, serial idle segments are all zero and skipped
    always @(posedge clk_sys) begin
        if (armed && rx_valid === 1'b1 && !(!mode_strap[1] && rx_word === '0) && q_down.size() > 0) begin
            {ew, em} = q_down.pop_front();
            chk_word("rx_word", ew, rx_word);
            chk_small("rx_carrier", exp_mask(!mode_strap[1], em, 8'h00), rx_carrier);
        end
        if (armed && got_valid === 1'b1 && !(!mode_strap[1] && got_word === '0) && q_up.size() > 0) begin
            {ew, em} = q_up.pop_front();
            chk_word("got_word", ew, got_word);
            chk_small("got_en", exp_mask(!mode_strap[1], em, 8'hff), got_en);
        end
    end
    // main sequence and watchdog
    initial begin
        fork
            begin
                repeat (80000) @(posedge clk_sys);
                n_errors++;
                conclude();
            end
        join_none
        for (int r = 0; r < 6; r++) begin
            armed = 1'b0;
            nrst = 1'b0;
            mode_strap = straps[r];
            slow_mode = slows[r];
            q_up.delete();
            q_down.delete();
            repeat (5) @(posedge clk_sys);
            #2 nrst = 1'b1;
            repeat (200) @(posedge clk_sys);
            #2 chk_small("fmt", 8'(exp_fmt(mode_strap)), 8'(fmt));
            armed = 1'b1;
            fork
                push_words(1'b0, 5);
                push_words(1'b1, 5);
            join
            k = 0;
            while (q_up.size() + q_down.size() != 0 && k++ < 4000)
                @(posedge clk_sys);
            chk_small("words left", 8'h00, 8'(q_up.size() + q_down.size()));
            @(posedge clk_sys);
            #2;
        end
        conclude();
    end
endmodule

// file: phy_port_end.sv
// module: phy end of the link, drives reference clock and receive lanes, captures transmit lanes
`timescale 1ns/1ps
// Operation
// R1: rmii transmit enable marks valid di-bits only
// R2: serial formats ignore per-port transmit enables
// R3: source-sync: mac drives tx clock on enable 4
// R4: rmii receive di-bits timed to reference clock
// R5: smii receive segments start at shared sync
// R6: slow smii repeats each receive segment ten times
// R7: source-sync receive segments follow own rx sync
// R8: mac ignores second receive bit in serial formats
// R9: rmii carrier-sense follows non-idle medium
// R10: smii holds all carrier-sense outputs low
// R11: source-sync rx sync on port 3 carrier pin
// R12: source-sync rx clock on port 4 carrier pin
// R13: smii shared sync marks both lane boundaries
// R14: source-sync tx sync marks transmit boundaries
// R15: two-bit strap selects rmii, smii or source-sync
// R16: phy drives reference clock from own clock
// R17: slow mac repeats each transmit segment ten times
// R18: strap captured once at reset release
// R19: eight ports parallel, shared sync and clocks
module phy_port_end import link_pkg::*; (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // format strap and speed
    input  wire logic [1:0]        mode_strap,
    input  wire logic              slow_mode,
    output fmt_t                   fmt,
    // link pins
    mac_link_if.phy                lnk,
    // words to send on the receive lanes
    input  wire logic              send_valid,
    output logic                   send_ready,
    input  wire logic [WORD_W-1:0] send_word,
    input  wire logic [NPORTS-1:0] send_carrier,
    // words captured from the transmit lanes
    output logic                   got_valid,
    output logic [WORD_W-1:0]      got_word,
    output logic [NPORTS-1:0]      got_en
);
    logic [1:0]        strap_s1;
    logic [1:0]        strap_s2;
    fmt_t              fmt_reg;
    logic              fmt_done_reg;
    logic              is_rmii;
    logic              is_ss;

    // strap pins pass two flops
    always_ff @(posedge clk_sys) begin
        strap_s1 <= mode_strap;
        strap_s2 <= strap_s1;
    end

    // format latched once after reset release, then fixed
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            fmt_reg      <= decode_fmt(STRAP_DEFAULT);
            fmt_done_reg <= 1'b0;
        end else if (!fmt_done_reg) begin
            fmt_reg      <= decode_fmt(strap_s2); // [R15] [R18]
            fmt_done_reg <= 1'b1;
        end
    end
    assign fmt     = fmt_reg;
    assign is_rmii = fmt_reg == FMT_RMII;
    assign is_ss   = fmt_reg == FMT_SOURCE_SYNC;

    // reference and receive clock divider
    logic [3:0] div_reg;
    logic       lclk_reg;
    logic       half_end;
    logic       lrise;
    logic       lfall;
    assign half_end = div_reg == HALF_LAST;
    assign lrise    = half_end && !lclk_reg;
    assign lfall    = half_end && lclk_reg;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {div_reg, lclk_reg} <= '0;
        end else begin
            div_reg <= half_end ? 4'h0 : div_reg + 4'h1;
            if (half_end)
                lclk_reg <= !lclk_reg; // [R16]
        end
    end
    assign lnk.refclk = lclk_reg; // [R16]

    // transmit pins pass two flops
    logic [NPORTS-1:0] txd0_s1, txd0_s2;
    logic [NPORTS-1:0] txd1_s1, txd1_s2;
    logic [NPORTS-1:0] txen_s1, txen_s2;
    logic              sync_s1, sync_s2;
    logic              txclk_d;
    always_ff @(posedge clk_sys) begin
        {txd0_s1, txd1_s1, txen_s1, sync_s1} <= {lnk.txd0, lnk.txd1, lnk.tx_en, lnk.sync};
        {txd0_s2, txd1_s2, txen_s2, sync_s2} <= {txd0_s1, txd1_s1, txen_s1, sync_s1};
        txclk_d <= txen_s2[SS_CLK_BIT];
    end

    // transmit capture point: own reference rise, or rise of mac clock
    logic              tx_take;
    logic [3:0]        tidx;
    logic [3:0]        tpos_reg;
    logic [3:0]        trep_reg;
    logic [WORD_W-1:0] tacc_reg;
    logic [WORD_W-1:0] tacc_next;
    logic [NPORTS-1:0] ten_reg;
    logic              tseg_end;
    assign tx_take = is_ss ? (txen_s2[SS_CLK_BIT] && !txclk_d) : lrise; // [R3]

    // bit position, sync restarts a serial segment
    always_comb begin
        tidx      = is_rmii ? {tpos_reg[2:0], 1'b0} : (sync_s2 ? 4'h0 : tpos_reg); // [R13] [R14]
        tacc_next = place_bits(tacc_reg, tidx, txd0_s2);
        if (is_rmii)
            tacc_next = place_bits(tacc_next, tidx | 4'h1, txd1_s2);
    end
    assign tseg_end = is_rmii ? (tpos_reg == DIBIT_LAST) : (tidx == SEG_LAST);

    // transmit word assembly and hand-off
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {tpos_reg, trep_reg, tacc_reg, ten_reg} <= '0;
            {got_valid, got_word, got_en} <= '0;
        end else begin
            got_valid <= 1'b0;
            if (tx_take && is_rmii && txen_s2 == '0) begin
                tpos_reg <= 4'h0; // [R1] idle realigns di-bit count
            end else if (tx_take) begin
                // serial formats drop the enables, source-sync only clocks on enable 4 [R2]
                tacc_reg <= tacc_next;
                ten_reg  <= (tidx == 4'h0) ? txen_s2 : (ten_reg | txen_s2); // [R1]
                tpos_reg <= tseg_end ? 4'h0 : (is_rmii ? tpos_reg : tidx) + 4'h1;
                if (tseg_end) begin
                    if (!is_rmii)
                        trep_reg <= (!slow_mode || trep_reg == REPEAT_LAST) ? 4'h0 : trep_reg + 4'h1;
                    got_valid <= is_rmii || !slow_mode || trep_reg == 4'h0; // [R17] first copy only
                    got_word  <= tacc_next;
                    got_en    <= is_rmii ? (ten_reg | txen_s2) : '1; // [R2]
                end
            end
        end
    end

    // buffer in front of the receive lanes
    logic                     buf_valid;
    logic [WORD_W+NPORTS-1:0] buf_data;
    logic                     rwrap;
    logic                     rload;
    stream_buf2 #(.WIDTH(WORD_W + NPORTS), .DEPTH(BUF_DEPTH)) u_buf (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_valid  (send_valid),
        .in_ready  (send_ready),
        .in_data   ({send_carrier, send_word}),
        .out_valid (buf_valid),
        .out_ready (rload),
        .out_data  (buf_data)
    );

    // receive segment boundary per format
    logic [3:0]        rpos_reg;
    logic [3:0]        rrep_reg;
    logic              sync_seen_reg;
    logic [WORD_W-1:0] cur_reg;
    logic [NPORTS-1:0] dv_reg;
    always_comb begin
        unique case (fmt_reg)
            FMT_RMII:        rwrap = rpos_reg >= DIBIT_LAST; // [R4]
            FMT_SMII:        rwrap = sync_seen_reg; // [R5] [R13]
            FMT_SOURCE_SYNC: rwrap = rpos_reg == SEG_LAST; // [R7]
            default:         rwrap = 1'b0;
        endcase
    end
    // new word only after the tenth copy at 10 Mbit/s
    assign rload = lfall && rwrap && (is_rmii || !slow_mode || rrep_reg == REPEAT_LAST); // [R6]

    // receive position, repeats and current word, stepped on falling edge
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {rrep_reg, sync_seen_reg, cur_reg, dv_reg} <= '0;
            rpos_reg <= SEG_LAST; // rx sync first rises with a clock fall [R11]
        end else begin
            if (lrise)
                sync_seen_reg <= sync_s2; // [R5]
            if (lfall) begin
                if (rwrap)
                    rpos_reg <= 4'h0;
                else if (rpos_reg != SEG_LAST)
                    rpos_reg <= rpos_reg + 4'h1;
                if (rwrap && !is_rmii)
                    rrep_reg <= (!slow_mode || rrep_reg == REPEAT_LAST) ? 4'h0 : rrep_reg + 4'h1; // [R6]
            end
            if (rload) begin
                cur_reg <= buf_valid ? buf_data[WORD_W-1:0] : '0;
                dv_reg  <= buf_valid ? buf_data[WORD_W +: NPORTS] : '0; // [R9] empty buffer is idle
            end
        end
    end

    // receive pins, all ports side by side
    logic [NPORTS-1:0] rxd0_reg;
    logic [NPORTS-1:0] rxd1_reg;
    logic [NPORTS-1:0] crs_reg;
    logic [3:0]        ridx;
    assign ridx = is_rmii ? {rpos_reg[2:0], 1'b0} : rpos_reg;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {rxd0_reg, rxd1_reg, crs_reg} <= '0;
        end else begin
            rxd0_reg <= lane_bits(cur_reg, ridx); // [R4] [R5] [R7] [R19]
            rxd1_reg <= is_rmii ? lane_bits(cur_reg, ridx | 4'h1) : '0; // [R4] [R8]
            unique case (fmt_reg)
                FMT_RMII: begin
                    crs_reg <= dv_reg; // [R9]
                end
                FMT_SOURCE_SYNC: begin
                    crs_reg              <= '0;
                    crs_reg[SS_SYNC_BIT] <= rpos_reg == 4'h0; // [R11]
                    crs_reg[SS_CLK_BIT]  <= lclk_reg; // [R12]
                end
                default: begin
                    crs_reg <= '0; // [R10]
                end
            endcase
        end
    end
    assign lnk.rxd0   = rxd0_reg;
    assign lnk.rxd1   = rxd1_reg;
    assign lnk.crs_dv = crs_reg;
endmodule

// file: stream_buf2.sv
// module: small ring buffer with valid and ready on both sides
`timescale 1ns/1ps
module stream_buf2 import link_pkg::*; #(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = BUF_DEPTH
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    // honest full and empty from the fill count
    assign in_ready  = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage, depth is a power of two
    always_ff @(posedge clk_sys) begin
        if (push)
            mem_reg[wr_reg] <= in_data;
    end

    // pointers and count
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {wr_reg, rd_reg, cnt_reg} <= '0;
        end else begin
            wr_reg  <= wr_reg + AW'(push);
            rd_reg  <= rd_reg + AW'(pop);
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
